// File: design/ppm_buf2.sv
// two-entry valid/ready buffer with unregistered read data muxed from the slots
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
module ppm_buf2 (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [7:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [7:0] o_data
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] mem_q [0:1]; // two byte slots
  logic wp_q; // write slot
  logic rp_q; // read slot
  logic [1:0] cnt_q; // fill count
  logic push;
  logic pop;
  assign push = i_valid && (cnt_q != 2'h2);
  assign pop = o_valid && i_ready;
  assign o_ready = (cnt_q != 2'h2); // honest full, stalls the source
  assign o_valid = (cnt_q != 2'h0);
  // write a slot on push
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
      wp_q <= 1'b0;
    end else if (push) begin
      mem_q[wp_q] <= i_data;
      wp_q <= ~wp_q;
    end
  end
  // advance read side and count
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
  // head word read straight from the slot register
  assign o_data = mem_q[rp_q];
endmodule : ppm_buf2
`default_nettype wire

// File: design/ppm_map.svh
// constants for the parallel port address/data multiplexer
// assumes one 100 MHz clock and plain control ports, no register bus
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH
// ----------------------------------------
// field encodings
// ----------------------------------------
`define PPM_MUX_DEMUX 2'h0
`define PPM_MUX_ONE 2'h1
`define PPM_MUX_TWO 2'h2
`define PPM_MUX_THREE 2'h3
`define PPM_WIDTH_8 2'h0
`define PPM_WIDTH_4 2'h1
`define PPM_MODE_MASTER 2'h3
`define PPM_CSF_PIN14 2'h2
// ----------------------------------------
// timing and reset values
// ----------------------------------------
`define PPM_PHASE_NS 20
`define PPM_CLK_NS 10
`define PPM_PHASE_CYC (((`PPM_PHASE_NS) + (`PPM_CLK_NS) - 1) / (`PPM_CLK_NS))
`define PPM_ACK_TMO 8'h40
`define PPM_RST_BYTE 8'h00
`endif

// File: design/ppm_pkg.sv
// types shared by the parallel port files
// assumes ppm_map.svh for the numbers
package ppm_pkg;
  // master request carried as one word
  typedef struct packed {
    logic wr;
    logic cs_two;
    logic [22:0] addr;
    logic [7:0] data;
  } ppm_req_s;
  // sequencer states
  typedef enum logic [2:0] {
    PPM_IDLE = 3'b000,
    PPM_ALL = 3'b001,
    PPM_ALH = 3'b010,
    PPM_ALU = 3'b011,
    PPM_DATA = 3'b100,
    PPM_DONE = 3'b101
  } ppm_state_e;
endpackage : ppm_pkg

// File: design/ppm_top.sv
// parallel port pin multiplexer: master sequencer and slave buffers
// assumes synchronous control inputs and a single clock
`timescale 1ns/1ps
`default_nettype none
`include "ppm_map.svh"
module ppm_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // configuration
  input wire logic [1:0] i_addr_mux_select,
  input wire logic [1:0] i_port_width_select,
  input wire logic [1:0] i_port_mode,
  input wire logic [1:0] i_cs_function,
  input wire logic i_strobe_mode_bit,
  // master requests
  input wire logic i_req_valid,
  input wire ppm_pkg::ppm_req_s i_req,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [7:0] o_in_buffer_a,
  output logic o_timeout,
  // slave side internal access
  input wire logic i_out_valid,
  input wire logic [7:0] i_out_data,
  output logic o_out_ready,
  output logic o_in_valid,
  input wire logic i_in_ready,
  output logic [7:0] o_in_data,
  // pins
  output logic [14:0] o_port_address_pins,
  output logic [7:0] o_port_data_pins,
  output logic [7:0] o_port_data_oe,
  input wire logic [7:0] i_port_data_pins,
  output logic o_chip_select_one,
  output logic o_chip_select_two,
  output logic o_write_strobe_pin,
  output logic o_read_strobe_pin,
  output logic o_high_lane_indicator,
  output logic o_low_lane_indicator,
  input wire logic i_ack_input_one,
  input wire logic i_ack_input_two,
  input wire logic i_host_cs,
  input wire logic i_host_wr,
  input wire logic i_host_rd
);
  import ppm_pkg::*;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // number of latch phases for a mux setting
  function automatic logic [1:0] phases(input logic [1:0] mux);
    phases = mux;
  endfunction : phases
  // state and request holding
  ppm_state_e st_q;
  ppm_req_s req_q;
  logic [1:0] tmr_q; // phase length counter
  logic [7:0] ack_q; // ack wait counter
  logic master;
  logic narrow;
  logic ack_in;
  logic phase_end;
  assign master = (i_port_mode == `PPM_MODE_MASTER);
  assign narrow = (i_port_width_select == `PPM_WIDTH_4);
  assign ack_in = req_q.cs_two ? i_ack_input_two : i_ack_input_one;
  assign phase_end = (tmr_q == 2'(`PPM_PHASE_CYC - 1));
  // ----------------------------------------
  // master sequencer
  // ----------------------------------------
  // walk the address phases the mux setting asks for
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= PPM_IDLE;
      req_q <= '0;
      tmr_q <= 2'h0;
      ack_q <= 8'h00;
    end else begin
      tmr_q <= phase_end ? 2'h0 : tmr_q + 2'h1;
      case (st_q)
        PPM_IDLE: begin
          tmr_q <= 2'h0;
          ack_q <= 8'h00;
          if (master && i_req_valid) begin
            req_q <= i_req;
            // 00 goes straight to data, others latch first
            st_q <= (phases(i_addr_mux_select) == 2'h0) ? PPM_DATA : PPM_ALL;
          end
        end
        PPM_ALL: begin
          if (phase_end) begin
            st_q <= (phases(i_addr_mux_select) >= 2'h2) ? PPM_ALH : PPM_DATA;
          end
        end
        PPM_ALH: begin
          if (phase_end) begin
            st_q <= (phases(i_addr_mux_select) == 2'h3) ? PPM_ALU : PPM_DATA;
          end
        end
        PPM_ALU: begin
          if (phase_end) begin
            st_q <= PPM_DATA;
          end
        end
        PPM_DATA: begin
          tmr_q <= 2'h0;
          ack_q <= ack_q + 8'h01;
          // completes on ack or after a bounded wait
          if (ack_in || (ack_q == `PPM_ACK_TMO)) begin
            st_q <= PPM_DONE;
          end
        end
        default: begin
          st_q <= PPM_IDLE;
        end
      endcase
    end
  end
  // address phase payload per state and width
  logic [7:0] addr_byte;
  always_comb begin
    addr_byte = 8'h00;
    if (narrow) begin
      case (st_q)
        PPM_ALL: addr_byte = (phases(i_addr_mux_select) == 2'h1) ?
          req_q.addr[7:0] : {4'h0, req_q.addr[3:0]};
        PPM_ALH: addr_byte = {4'h0, req_q.addr[7:4]};
        PPM_ALU: addr_byte = {4'h0, req_q.addr[11:8]};
        default: addr_byte = 8'h00;
      endcase
    end else begin
      case (st_q)
        PPM_ALL: addr_byte = req_q.addr[7:0];
        PPM_ALH: addr_byte = req_q.addr[15:8];
        PPM_ALU: addr_byte = {1'b0, req_q.addr[22:16]};
        default: addr_byte = 8'h00;
      endcase
    end
  end
  // ----------------------------------------
  // pin drivers, all registered
  // ----------------------------------------
  logic in_phase;
  logic data_ph;
  logic sob_valid; // outgoing buffer holds a byte for the host
  logic [7:0] sob_data; // head byte of the outgoing buffer
  assign in_phase = (st_q == PPM_ALL) || (st_q == PPM_ALH) ||
    (st_q == PPM_ALU);
  assign data_ph = (st_q == PPM_DATA);
  // address pins, latch strobes and chip selects
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_port_address_pins <= 15'h0000;
      o_chip_select_one <= 1'b0;
      o_chip_select_two <= 1'b0;
    end else begin
      o_port_address_pins <= 15'h0000;
      if (i_addr_mux_select == `PPM_MUX_DEMUX) begin
        o_port_address_pins[9:0] <= req_q.addr[9:0];
      end else begin
        o_port_address_pins[0] <= (st_q == PPM_ALL);
        o_port_address_pins[1] <= (st_q == PPM_ALH);
        o_port_address_pins[2] <= (st_q == PPM_ALU);
        if (narrow && (i_addr_mux_select == `PPM_MUX_THREE)) begin
          o_port_address_pins[13:12] <= req_q.addr[13:12];
        end else if (narrow) begin
          o_port_address_pins[9:8] <= req_q.addr[9:8];
        end
      end
      // pin fourteen carries chip select one when chosen
      if (i_cs_function == `PPM_CSF_PIN14) begin
        o_port_address_pins[14] <= (in_phase || data_ph) && !req_q.cs_two;
        o_chip_select_one <= 1'b0;
      end else begin
        o_chip_select_one <= (in_phase || data_ph) && !req_q.cs_two;
      end
      o_chip_select_two <= (in_phase || data_ph) && req_q.cs_two;
    end
  end
  // data pins, strobes and lane indicators
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_port_data_pins <= `PPM_RST_BYTE;
      o_port_data_oe <= 8'h00;
      o_write_strobe_pin <= 1'b0;
      o_read_strobe_pin <= 1'b0;
      o_high_lane_indicator <= 1'b0;
      o_low_lane_indicator <= 1'b0;
    end else begin
      o_port_data_pins <= `PPM_RST_BYTE;
      o_port_data_oe <= 8'h00;
      if (master && in_phase) begin
        // the latch takes this value while its strobe is up
        o_port_data_pins <= addr_byte;
        o_port_data_oe <= narrow && (i_addr_mux_select != `PPM_MUX_ONE) ?
          8'h0f : 8'hff;
      end else if (master && data_ph && req_q.wr) begin
        o_port_data_pins <= req_q.data;
        o_port_data_oe <= narrow ? 8'h0f : 8'hff;
      end else if (!master && i_host_cs && i_host_rd) begin
        // an empty buffer reads as the idle byte, never a stale one
        o_port_data_pins <= sob_valid ? sob_data : `PPM_RST_BYTE;
        o_port_data_oe <= 8'hff;
      end
      // separate strobes, or direction plus enable
      if (master && i_strobe_mode_bit) begin
        o_read_strobe_pin <= data_ph && !req_q.wr;
        o_write_strobe_pin <= data_ph;
      end else if (master) begin
        o_read_strobe_pin <= data_ph && !req_q.wr;
        o_write_strobe_pin <= data_ph && req_q.wr;
      end else begin
        o_read_strobe_pin <= 1'b0;
        o_write_strobe_pin <= 1'b0;
      end
      o_high_lane_indicator <= master && data_ph && !narrow;
      o_low_lane_indicator <= master && data_ph;
    end
  end
  // ----------------------------------------
  // master read capture and handshakes
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_in_buffer_a <= 8'h00;
      o_rd_valid <= 1'b0;
      o_timeout <= 1'b0;
      o_req_ready <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      o_timeout <= 1'b0;
      o_req_ready <= master && (st_q == PPM_IDLE) && !i_req_valid;
      if (data_ph && (ack_in || (ack_q == `PPM_ACK_TMO))) begin
        if (!req_q.wr) begin
          o_in_buffer_a <= narrow ? {4'h0, i_port_data_pins[3:0]} :
            i_port_data_pins;
          o_rd_valid <= 1'b1;
        end
        o_timeout <= !ack_in;
      end
    end
  end
  // ----------------------------------------
  // slave side: strobe synchronisers and buffers
  // ----------------------------------------
  logic [2:0] wr_s1_q;
  logic [2:0] wr_s2_q;
  logic [7:0] dat_s1_q;
  logic [7:0] dat_s2_q;
  logic wr_prev_q;
  logic rd_prev_q;
  logic [7:0] dat_prev_q; // byte sampled with the previous strobe sample
  // two stages before any logic but the slave read data drive looks at host strobes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_s1_q <= 3'h0;
      wr_s2_q <= 3'h0;
      dat_s1_q <= 8'h00;
      dat_s2_q <= 8'h00;
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      dat_prev_q <= 8'h00;
    end else begin
      wr_s1_q <= {i_host_rd, i_host_wr, i_host_cs};
      wr_s2_q <= wr_s1_q;
      dat_s1_q <= i_port_data_pins;
      dat_s2_q <= dat_s1_q;
      // keep the byte aligned with the strobe edge detector, so the
      // pushed byte is the one seen while the host strobe was still up
      dat_prev_q <= dat_s2_q;
      wr_prev_q <= wr_s2_q[1] && wr_s2_q[0];
      rd_prev_q <= wr_s2_q[2] && wr_s2_q[0];
    end
  end
  // falling edge of a host write pushes one byte
  logic host_push;
  logic host_pop;
  assign host_push = !master && wr_prev_q && !(wr_s2_q[1] && wr_s2_q[0]);
  assign host_pop = !master && rd_prev_q && !(wr_s2_q[2] && wr_s2_q[0]);
  // up to two incoming bytes held until internal logic reads them, more are dropped
  ppm_buf2 u_in_buf (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(host_push),
    .o_ready(),
    .i_data(dat_prev_q),
    .o_valid(o_in_valid),
    .i_ready(i_in_ready),
    .o_data(o_in_data)
  );
  // outgoing bytes wait for the host to read them
  ppm_buf2 u_out_buf (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(i_out_valid && !master),
    .o_ready(o_out_ready),
    .i_data(i_out_data),
    .o_valid(sob_valid),
    .i_ready(host_pop),
    .o_data(sob_data)
  );
endmodule : ppm_top
`default_nettype wire

// File: dv/ppm_mem_model.sv
// external memory behind the parallel port pins
// assumes active-high strobes and a registered pin set
`timescale 1ns/1ps
`default_nettype none
module ppm_mem_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // setup from the bench
  input wire logic [1:0] i_mux,
  input wire logic i_w4,
  input wire logic i_sm,
  input wire logic [7:0] i_delay,
  input wire logic i_noack,
  input wire logic [7:0] i_rdata,
  // pins
  input wire logic [14:0] i_a,
  input wire logic [7:0] i_d,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_cs_two,
  output logic [7:0] o_data,
  output logic o_ack_one,
  output logic o_ack_two,
  // what was seen
  output logic [22:0] o_addr,
  output logic [7:0] o_wdata
);
  logic [7:0] cnt_q; // cycles in data phase
  logic ack_q;
  wire logic act = i_sm ? i_wr : (i_rd | i_wr);
  assign o_ack_one = ack_q & !i_cs_two;
  assign o_ack_two = ack_q & i_cs_two;
  // ----------------------------------------
  // answer: ack after delay, released bus toggles
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 8'h00;
      ack_q <= 1'b0;
      o_data <= 8'h00;
    end else begin
      cnt_q <= act ? cnt_q + 8'h01 : 8'h00;
      ack_q <= act && !i_noack && cnt_q >= i_delay;
      // hold time over: show no stale byte
      o_data <= (act && i_rd) ? i_rdata : ~o_data;
    end
  end
  // ----------------------------------------
  // address latch and write capture
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_mux != 2'h0 && i_a[0]) begin
      if (!i_w4 || i_mux == 2'h1) o_addr[7:0] <= i_d;
      else o_addr[3:0] <= i_d[3:0];
    end
    if (i_mux != 2'h0 && i_a[1]) begin
      if (i_w4) o_addr[7:4] <= i_d[3:0];
      else o_addr[15:8] <= i_d;
    end
    if (i_mux != 2'h0 && i_a[2]) begin
      if (i_w4) o_addr[11:8] <= i_d[3:0];
      else o_addr[22:16] <= i_d[6:0];
    end
    if (act && i_mux == 2'h0) o_addr[9:0] <= i_a[9:0];
    if (act && i_w4 && i_mux == 2'h3) o_addr[13:12] <= i_a[13:12];
    else if (act && i_w4 && i_mux != 2'h0) o_addr[9:8] <= i_a[9:8];
    if (act && !i_rd && ack_q) o_wdata <= i_w4 ? {4'h0, i_d[3:0]} : i_d;
  end
endmodule : ppm_mem_model
`default_nettype wire

// File: dv/ppm_top_asserts.sv
// checker for the parallel port pin multiplexer top
// assumes the ppm_top ports as declared; bound after the module
`timescale 1ns/1ps
`default_nettype none
module ppm_top_asserts (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // configuration and requests
  input wire logic [1:0] i_addr_mux_select,
  input wire logic [1:0] i_port_width_select,
  input wire logic [1:0] i_port_mode,
  input wire logic [1:0] i_cs_function,
  input wire logic i_strobe_mode_bit,
  input wire logic i_req_valid,
  input wire logic i_in_ready,
  // watched outputs
  input wire logic o_req_ready,
  input wire logic o_rd_valid,
  input wire logic o_timeout,
  input wire logic o_in_valid,
  input wire logic [7:0] o_in_data,
  input wire logic [14:0] o_port_address_pins,
  input wire logic [7:0] o_port_data_oe,
  input wire logic o_chip_select_two,
  input wire logic o_write_strobe_pin,
  input wire logic o_read_strobe_pin,
  input wire logic o_chip_select_one,
  input wire logic o_high_lane_indicator,
  input wire logic o_low_lane_indicator
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // latch strobes share address pins 0..2
  wire logic [2:0] ls = o_port_address_pins[2:0];
  wire logic mx = i_addr_mux_select != 2'h0;
  // separate strobes only; the write pin is also high during reads otherwise
  wire logic sep = !i_strobe_mode_bit;
  wire logic st = o_read_strobe_pin | o_write_strobe_pin;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_latch_two_cyc: assert property (
    mx && $rose(ls[0]) |=> ls[0] ##1 !ls[0])
    else $error("low latch strobe not two cycles");
  a_low_then_high: assert property (
    i_addr_mux_select[1] && $fell(ls[0]) |-> ##[0:2] ls[1])
    else $error("high latch phase missing");
  a_latch_no_strobe: assert property (
    mx && sep && (|ls) |-> !st)
    else $error("strobe during address phase");
  a_read_no_drive: assert property (
    sep && i_port_mode == 2'h3 && o_read_strobe_pin |-> o_port_data_oe == 8'h00)
    else $error("data driven during read");
  a_lane_marks: assert property (
    sep && st |-> o_low_lane_indicator)
    else $error("lane indicator low in data phase");
  a_rd_one_cyc: assert property (
    o_rd_valid |=> !o_rd_valid)
    else $error("read valid longer than one cycle");
  a_tmo_one_cyc: assert property (
    o_timeout |=> !o_timeout)
    else $error("timeout longer than one cycle");
  a_req_taken: assert property (
    i_port_mode == 2'h3 && i_req_valid && o_req_ready |=> !o_req_ready)
    else $error("ready stayed high after take");
  a_in_held: assert property (
    o_in_valid && !i_in_ready |=> o_in_valid && $stable(o_in_data))
    else $error("incoming byte lost before read");
  a_cs_pin14: assert property (
    i_cs_function == 2'h2 && sep && st && !o_chip_select_two
      |-> o_port_address_pins[14])
    else $error("pin fourteen not acting as chip select");
  a_cs_one_pin: assert property (
    i_cs_function == 2'h0 && sep && st && !o_chip_select_two
      |-> o_chip_select_one)
    else $error("chip select one low in data phase");
  a_high_lane: assert property (
    sep && st |-> o_high_lane_indicator == (i_port_width_select != 2'h1))
    else $error("high lane indicator wrong for port width");
endmodule : ppm_top_asserts
bind ppm_top ppm_top_asserts ppm_top_asserts_inst (
  .i_clk, .i_rst_n, .i_addr_mux_select, .i_port_mode, .i_cs_function,
  .i_strobe_mode_bit, .i_req_valid, .i_in_ready, .o_req_ready,
  .o_rd_valid, .o_timeout, .o_in_valid, .o_in_data, .o_port_address_pins,
  .o_port_data_oe, .o_chip_select_two, .o_write_strobe_pin,
  .o_read_strobe_pin, .o_low_lane_indicator, .i_port_width_select,
  .o_chip_select_one, .o_high_lane_indicator
);
`default_nettype wire

// File: dv/ppm_top_tb.sv
// testbench for the parallel port pin multiplexer
// assumes ppm_mem_model on the pins and the bound checker
`timescale 1ns/1ps
`default_nettype none
module ppm_top_tb;
  import ppm_pkg::*;
  logic i_clk, i_rst_n, i_strobe_mode_bit, i_req_valid, o_req_ready;
  logic [1:0] i_addr_mux_select, i_port_width_select, i_port_mode;
  logic [1:0] i_cs_function;
  ppm_req_s i_req;
  logic o_rd_valid, o_timeout, i_out_valid, o_out_ready, o_in_valid;
  logic i_in_ready, o_chip_select_one, o_chip_select_two;
  logic [7:0] o_in_buffer_a, i_out_data, o_in_data, o_port_data_pins;
  logic [7:0] o_port_data_oe, i_port_data_pins, host_d, mem_d, rdata;
  logic [7:0] delay, mw, got, dm;
  logic [14:0] o_port_address_pins;
  logic o_write_strobe_pin, o_read_strobe_pin, o_high_lane_indicator;
  logic o_low_lane_indicator, i_ack_input_one, i_ack_input_two;
  logic i_host_cs, i_host_wr, i_host_rd, noack, seen_rd, seen_tmo;
  logic [22:0] ma, a, am;
  int n_fail = 0;
  int cmp_count = 0;
  int tcnt;
  // bus level: whoever enables its driver wins the bit
  assign i_port_data_pins = (o_port_data_oe & o_port_data_pins) |
    (~o_port_data_oe & (i_port_mode == 2'h3 ? mem_d : host_d));
  ppm_top ppm_top_inst (.i_clk, .i_rst_n, .i_addr_mux_select,
    .i_port_width_select, .i_port_mode, .i_cs_function, .i_strobe_mode_bit,
    .i_req_valid, .i_req, .o_req_ready, .o_rd_valid, .o_in_buffer_a,
    .o_timeout, .i_out_valid, .i_out_data, .o_out_ready, .o_in_valid,
    .i_in_ready, .o_in_data, .o_port_address_pins, .o_port_data_pins,
    .o_port_data_oe, .i_port_data_pins, .o_chip_select_one,
    .o_chip_select_two, .o_write_strobe_pin, .o_read_strobe_pin,
    .o_high_lane_indicator, .o_low_lane_indicator, .i_ack_input_one,
    .i_ack_input_two, .i_host_cs, .i_host_wr, .i_host_rd);
  ppm_mem_model ppm_mem_model_inst (.i_clk, .i_rst_n,
    .i_mux(i_addr_mux_select), .i_w4(i_port_width_select[0]),
    .i_sm(i_strobe_mode_bit), .i_delay(delay), .i_noack(noack),
    .i_rdata(rdata), .i_a(o_port_address_pins), .i_d(o_port_data_pins),
    .i_rd(o_read_strobe_pin), .i_wr(o_write_strobe_pin),
    .i_cs_two(o_chip_select_two), .o_data(mem_d),
    .o_ack_one(i_ack_input_one), .o_ack_two(i_ack_input_two),
    .o_addr(ma), .o_wdata(mw));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // master access: wait for idle, offer the request for the one edge
  // at which the idle sequencer takes it, then wait for idle again
  task automatic mreq(input logic wr, input logic [22:0] ad);
    while (o_req_ready !== 1'b1) tick(1);
    i_req_valid = 1'b1;
    i_req = '{wr, 1'b0, ad, 8'h3c ^ ad[7:0]};
    tick(1);
    i_req_valid = 1'b0;
    seen_rd = 1'b0;
    seen_tmo = 1'b0;
    tcnt = 0;
    while ((o_req_ready !== 1'b1 || tcnt < 3) && tcnt < 300) begin
      if (o_rd_valid === 1'b1) begin
        seen_rd = 1'b1;
        got = o_in_buffer_a;
      end
      if (o_timeout === 1'b1) seen_tmo = 1'b1;
      tick(1);
      tcnt++;
    end
    if (tcnt >= 300) begin
      n_fail++;
      $display("mismatch at %0t: master access did not finish", $time);
    end
  endtask : mreq
  // host strobe held long enough for the two-flop synchroniser
  task automatic host(input logic w, input logic [7:0] b);
    host_d = b;
    i_host_cs = 1'b1;
    i_host_wr = w;
    i_host_rd = !w;
    tick(4);
    if (!w) chk(32'(o_port_data_pins), 32'(b));
    {i_host_cs, i_host_wr, i_host_rd} = 3'h0;
    host_d = ~b;
    tick(4);
  endtask : host
  // address bits reachable per width and phase count
  function automatic logic [22:0] amask(input int w, input int m);
    case (m)
      0: return 23'h3ff;
      1: return w ? 23'h3ff : 23'h0ff;
      2: return w ? 23'h3ff : 23'h0ffff;
      default: return w ? 23'h3fff : 23'h7fffff;
    endcase
  endfunction : amask
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #300000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end
  initial begin
    {i_rst_n, i_req_valid, i_out_valid, i_in_ready, noack} = 5'h00;
    {i_host_cs, i_host_wr, i_host_rd, i_strobe_mode_bit} = 4'h0;
    {i_addr_mux_select, i_port_width_select, i_cs_function} = 6'h00;
    i_port_mode = 2'h3;
    i_req = '0;
    {i_out_data, host_d, rdata, delay} = 32'h0;
    tick(4);
    i_rst_n = 1'b1;
    for (int w = 0; w < 2; w++) begin
      for (int m = 0; m < 4; m++) begin
        i_port_width_select = 2'(w);
        i_addr_mux_select = 2'(m);
        i_strobe_mode_bit = w[0];
        i_cs_function = m[1] ? 2'h2 : 2'h0;
        delay = 8'(2 + 3 * m);
        rdata = 8'h96 ^ 8'(m * 17);
        dm = w ? 8'h0f : 8'hff;
        am = amask(w, m);
        a = 23'h5b6ac5 ^ 23'(m * 23'h123456);
        mreq(1'b1, a);
        chk(32'(ma & am), 32'(a & am));
        chk(32'(mw & dm), 32'((8'h3c ^ a[7:0]) & dm));
        mreq(1'b0, ~a);
        chk(32'(ma & am), 32'(~a & am));
        chk(32'({seen_rd, got & dm}), 32'({1'b1, rdata & dm}));
        $display("test master width %0d phases %0d done", w, m);
      end
    end
    {i_addr_mux_select, i_port_width_select, i_strobe_mode_bit} = 5'h0;
    noack = 1'b1;
    mreq(1'b0, 23'h000155);
    chk(32'({seen_tmo, tcnt >= 64 && tcnt <= 76}), 32'h3);
    noack = 1'b0;
    $display("test missing acknowledge done");
    i_port_mode = 2'h0;
    host(1'b1, 8'ha1);
    host(1'b1, 8'hb2);
    host(1'b1, 8'hc3);
    for (int k = 0; k < 3; k++) begin
      // data behind a low valid carries no meaning, so only valid counts
      got = k < 2 ? o_in_data : 8'h00;
      chk(32'({o_in_valid, got}),
        k < 2 ? (k ? 32'h1b2 : 32'h1a1) : 32'h0);
      i_in_ready = 1'b1;
      tick(1);
      i_in_ready = 1'b0;
      tick(2);
    end
    {i_out_valid, i_out_data} = 9'h15e;
    while (o_out_ready !== 1'b1) tick(1);
    tick(1);
    i_out_data = 8'h6f;
    while (o_out_ready !== 1'b1) tick(1);
    tick(1);
    i_out_valid = 1'b0;
    chk(32'(o_out_ready), 32'h0);
    host(1'b0, 8'h5e);
    host(1'b0, 8'h6f);
    chk(32'(o_out_ready), 32'h1);
    $display("test slave buffers done");
    end_of_test();
  end
endmodule : ppm_top_tb
`default_nettype wire
